// File: include/port_alt_function_select_consts.svh
/*
 Register addresses, reset value and write mask of the pin function
 selector. Assumes it is included by its bare name where these are used.
*/
`ifndef PORT_ALT_FUNCTION_SELECT_CONSTS_SVH
`define PORT_ALT_FUNCTION_SELECT_CONSTS_SVH
`define PAFS_ADDR_PORT1   8'h91
`define PAFS_ADDR_PORT2   8'h92
`define PAFS_ADDR_PORT3   8'h93
`define PAFS_RESET_VALUE  8'h00
`define PAFS_P3_WMASK     8'hFC
`endif

// File: include/port_alt_function_select_pkg.sv
/*
 Types of the pin function selector. Assumes nothing beyond SystemVerilog.
*/
package port_alt_function_select_pkg;
   // Drive level and drive enable of one 8-bit port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_t;
   // Peripheral signals driven toward the pins
   typedef struct packed {
      logic       i2c_a_clock_line;
      logic       i2c_a_data_line;
      logic       i2c_b_clock_line;
      logic       i2c_b_data_line;
      logic [5:0] static_pulse_out;
      logic [1:0] dynamic_pulse_out;
      logic       pulse_out_6;
      logic       pulse_out_7;
      logic       clamp_pulse;
      logic       clamp_not_pulse;
      logic       pattern_generator_output;
      logic       vertical_sync_output;
      logic       horizontal_sync_output;
   } periph_out_t;
endpackage

// File: core/port_alt_function_select.sv
/*
 Pin function selector: three SFR select registers and the per-pin mux
 between general port bits and peripheral signals. Assumes an SFR write/read
 strobe pair in the CPU clock domain; pads resolve out/oe outside.
*/
`timescale 1ns/100ps
`include "port_alt_function_select_consts.svh"
module port_alt_function_select (
   input  wire logic                                      ref_clk_i,
   input  wire logic                                      rst_n_i,
   input  wire logic                                      clk_en_i,
   input  wire logic [7:0]                                sfr_addr_i,
   input  wire logic [7:0]                                sfr_wdata_i,
   input  wire logic                                      sfr_wr_i,
   input  wire logic                                      sfr_rd_i,
   output      logic [7:0]                                sfr_rdata_o,
   output      logic                                      sfr_hit_o,
   input  wire port_alt_function_select_pkg::pin_drive_t  port1_gen_i,
   input  wire port_alt_function_select_pkg::pin_drive_t  port2_gen_i,
   input  wire port_alt_function_select_pkg::pin_drive_t  port3_gen_i,
   input  wire port_alt_function_select_pkg::periph_out_t periph_i,
   input  wire logic [7:0]                                pulse_push_pull_i,
   input  wire logic [7:0]                                port1_pin_i,
   input  wire logic [7:0]                                port3_pin_i,
   output      port_alt_function_select_pkg::pin_drive_t  port1_pad_o,
   output      port_alt_function_select_pkg::pin_drive_t  port2_pad_o,
   output      port_alt_function_select_pkg::pin_drive_t  port3_pad_o,
   output      logic                                      i2c_a_data_in_o,
   output      logic                                      i2c_a_clock_in_o,
   output      logic                                      i2c_b_data_in_o,
   output      logic                                      i2c_b_clock_in_o,
   output      logic [3:0]                                analog_in_sel_o,
   output      logic                                      green_sync_input_o,
   output      logic [7:0]                                port1_function_select_o,
   output      logic [7:0]                                port2_function_select_o,
   output      logic [7:0]                                port3_function_select_o
);

   logic [7:0] port1_function_select;
   logic [7:0] port2_function_select;
   logic [7:0] port3_function_select;
   logic [7:0] next_port1_function_select;
   logic [7:0] next_port2_function_select;
   logic [7:0] next_port3_function_select;
   logic [7:0] next_rdata;
   logic       next_hit;
   port_alt_function_select_pkg::pin_drive_t p1;
   port_alt_function_select_pkg::pin_drive_t p2;
   port_alt_function_select_pkg::pin_drive_t p3;
   port_alt_function_select_pkg::pin_drive_t next_p1;
   port_alt_function_select_pkg::pin_drive_t next_p2;
   port_alt_function_select_pkg::pin_drive_t next_p3;
   logic [7:0] p1_sync1;
   logic [7:0] p1_sync2;
   logic [7:0] p1_sync3;
   logic [7:0] p1_stable;
   logic [7:0] next_p1_stable;
   logic       sog_sync1;
   logic       sog_sync2;
   logic       sog_sync3;
   logic       sog_stable;
   logic       next_sog_stable;
   logic [3:0] next_analog;
   logic [3:0] analog_sel;
   logic [3:0] i2c_in;
   logic [3:0] next_i2c_in;
   logic       sog_in;
   logic       next_sog_in;
   logic [7:0] pulse_src;

   // Open-drain drive: pull low when the signal is 0, release when 1
   function automatic logic [1:0] open_drain(input logic v);
      open_drain = {~v, 1'b0};
   endfunction

   // Decode a write or read on the select registers
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
      addr_is = (a == b);
   endfunction

   // Register writes and read mux
   always_comb
   begin
      next_port1_function_select = port1_function_select;
      next_port2_function_select = port2_function_select;
      next_port3_function_select = port3_function_select;
      next_rdata = 8'h00;
      next_hit = 1'b0;
      if (sfr_wr_i && addr_is(sfr_addr_i, `PAFS_ADDR_PORT1))
      begin
         next_port1_function_select = sfr_wdata_i;
      end
      if (sfr_wr_i && addr_is(sfr_addr_i, `PAFS_ADDR_PORT2))
      begin
         next_port2_function_select = sfr_wdata_i;
      end
      if (sfr_wr_i && addr_is(sfr_addr_i, `PAFS_ADDR_PORT3))
      begin
         // Reserved bits are held at 0 so they cannot steer a pin
         next_port3_function_select = sfr_wdata_i & `PAFS_P3_WMASK;
      end
      if (sfr_rd_i || sfr_wr_i)
      begin
         unique case (sfr_addr_i)
            `PAFS_ADDR_PORT1:
            begin
               next_rdata = port1_function_select;
               next_hit = 1'b1;
            end
            `PAFS_ADDR_PORT2:
            begin
               next_rdata = port2_function_select;
               next_hit = 1'b1;
            end
            `PAFS_ADDR_PORT3:
            begin
               next_rdata = port3_function_select;
               next_hit = 1'b1;
            end
            default:
            begin
               next_rdata = 8'h00;
               next_hit = 1'b0;
            end
         endcase
      end
   end

   // Select registers, cleared so every pin starts as a port bit
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         port1_function_select <= `PAFS_RESET_VALUE;
         port2_function_select <= `PAFS_RESET_VALUE;
         port3_function_select <= `PAFS_RESET_VALUE;
         sfr_rdata_o <= 8'h00;
         sfr_hit_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         port1_function_select <= next_port1_function_select;
         port2_function_select <= next_port2_function_select;
         port3_function_select <= next_port3_function_select;
         sfr_rdata_o <= next_rdata;
         sfr_hit_o <= next_hit;
      end
   end

   // Pulse sources in pin order: dynamic on bits 1,0, static above
   assign pulse_src = {periph_i.static_pulse_out,
                       periph_i.dynamic_pulse_out};

   // Pin muxes; a set bit switches the pin with nothing else needed
   always_comb
   begin
      next_p1 = port1_gen_i;
      next_p2 = port2_gen_i;
      next_p3 = port3_gen_i;
      next_analog = 4'h0;
      if (port1_function_select[7])
      begin
         {next_p1.oe[7], next_p1.out[7]} =
            open_drain(periph_i.i2c_b_data_line);
      end
      if (port1_function_select[6])
      begin
         {next_p1.oe[6], next_p1.out[6]} =
            open_drain(periph_i.i2c_b_clock_line);
      end
      if (port1_function_select[1])
      begin
         {next_p1.oe[1], next_p1.out[1]} =
            open_drain(periph_i.i2c_a_data_line);
      end
      if (port1_function_select[0])
      begin
         {next_p1.oe[0], next_p1.out[0]} =
            open_drain(periph_i.i2c_a_clock_line);
      end
      // Analog channels float the pad so the converter sees the pin
      for (int i = 0; i < 4; i++)
      begin
         if (port1_function_select[i+2])
         begin
            next_p1.oe[i+2] = 1'b0;
            next_p1.out[i+2] = 1'b0;
            next_analog[i] = 1'b1;
         end
      end
      // Pulse outputs: push-pull drives both levels, open-drain only low
      for (int i = 0; i < 8; i++)
      begin
         if (port2_function_select[i])
         begin
            next_p2.out[i] = pulse_src[i];
            next_p2.oe[i] = pulse_push_pull_i[i] | ~next_p2.out[i];
            if (!pulse_push_pull_i[i])
            begin
               next_p2.out[i] = 1'b0;
            end
         end
      end
      if (port3_function_select[7])
      begin
         next_p3.oe[7] = 1'b0;
         next_p3.out[7] = 1'b0;
      end
      if (port3_function_select[6])
      begin
         next_p3.oe[6] = 1'b1;
         next_p3.out[6] = periph_i.pattern_generator_output;
      end
      if (port3_function_select[5])
      begin
         next_p3.oe[5] = 1'b1;
         next_p3.out[5] = periph_i.clamp_not_pulse ? periph_i.clamp_pulse
                                                   : periph_i.pulse_out_7;
      end
      if (port3_function_select[4])
      begin
         next_p3.oe[4] = 1'b1;
         next_p3.out[4] = periph_i.pulse_out_6;
      end
      if (port3_function_select[3])
      begin
         next_p3.oe[3] = 1'b1;
         next_p3.out[3] = periph_i.vertical_sync_output;
      end
      if (port3_function_select[2])
      begin
         next_p3.oe[2] = 1'b1;
         next_p3.out[2] = periph_i.horizontal_sync_output;
      end
   end

   // Pin inputs: three stages, a change counts once stages two and three agree
   always_comb
   begin
      next_p1_stable = p1_stable;
      for (int i = 0; i < 8; i++)
      begin
         if (p1_sync2[i] == p1_sync3[i])
         begin
            next_p1_stable[i] = p1_sync3[i];
         end
      end
      next_sog_stable = (sog_sync2 == sog_sync3) ? sog_sync3 : sog_stable;
      // Unselected I2C inputs idle high so the controllers see a free bus
      next_i2c_in = {p1_stable[7:6], p1_stable[1:0]}
                  | ~{port1_function_select[7:6], port1_function_select[1:0]};
      next_sog_in = sog_stable & port3_function_select[7];
   end

   // Registered pad drive and synchronisers; outputs come from flops
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         p1 <= '0;
         p2 <= '0;
         p3 <= '0;
         p1_sync1 <= 8'hFF;
         p1_sync2 <= 8'hFF;
         p1_sync3 <= 8'hFF;
         p1_stable <= 8'hFF;
         sog_sync1 <= 1'b0;
         sog_sync2 <= 1'b0;
         sog_sync3 <= 1'b0;
         sog_stable <= 1'b0;
         analog_sel <= 4'h0;
         i2c_in <= 4'hF;
         sog_in <= 1'b0;
      end
      else if (clk_en_i)
      begin
         p1 <= next_p1;
         p2 <= next_p2;
         p3 <= next_p3;
         p1_sync1 <= port1_pin_i;
         p1_sync2 <= p1_sync1;
         p1_sync3 <= p1_sync2;
         p1_stable <= next_p1_stable;
         sog_sync1 <= port3_pin_i[7];
         sog_sync2 <= sog_sync1;
         sog_sync3 <= sog_sync2;
         sog_stable <= next_sog_stable;
         analog_sel <= next_analog;
         i2c_in <= next_i2c_in;
         sog_in <= next_sog_in;
      end
   end

   assign port1_pad_o = p1;
   assign port2_pad_o = p2;
   assign port3_pad_o = p3;
   // Peripheral inputs leave straight from their flops
   assign i2c_a_clock_in_o = i2c_in[0];
   assign i2c_a_data_in_o = i2c_in[1];
   assign i2c_b_clock_in_o = i2c_in[2];
   assign i2c_b_data_in_o = i2c_in[3];
   assign analog_in_sel_o = analog_sel;
   assign green_sync_input_o = sog_in;
   assign port1_function_select_o = port1_function_select;
   assign port2_function_select_o = port2_function_select;
   assign port3_function_select_o = port3_function_select;

endmodule

// File: tb/port_alt_function_select_asserts.sv
/* Checker of the pin function selector: select registers, SFR decode
   and pad mux. Assumes it is bound onto the top module by port name. */
`timescale 1ns/100ps
module port_alt_function_select_asserts (
   input wire logic                                      ref_clk_i,
   input wire logic                                      rst_n_i,
   input wire logic                                      clk_en_i,
   input wire logic [7:0]                                sfr_addr_i,
   input wire logic [7:0]                                sfr_wdata_i,
   input wire logic                                      sfr_wr_i,
   input wire logic                                      sfr_rd_i,
   input wire logic [7:0]                                sfr_rdata_o,
   input wire logic                                      sfr_hit_o,
   input wire port_alt_function_select_pkg::periph_out_t periph_i,
   input wire port_alt_function_select_pkg::pin_drive_t  port1_pad_o,
   input wire port_alt_function_select_pkg::pin_drive_t  port3_pad_o,
   input wire logic [7:0]                                port1_function_select_o,
   input wire logic [7:0]                                port2_function_select_o,
   input wire logic [7:0]                                port3_function_select_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Decode helpers; pad checks skip the edge after reset and frozen cycles
   logic req;
   logic mapped;
   logic live;
   assign req = clk_en_i && (sfr_wr_i || sfr_rd_i);
   assign mapped = sfr_addr_i inside {8'h91, 8'h92, 8'h93};
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         live <= 1'b0;
      else
         live <= clk_en_i;
   end
   a_reset_clear: assert property (
      !$past(rst_n_i) |-> {port1_function_select_o, port2_function_select_o,
      port3_function_select_o} == 24'h000000) else $error("select not clear");
   a_write_port1: assert property (
      clk_en_i && sfr_wr_i && sfr_addr_i == 8'h91 |=>
      port1_function_select_o == $past(sfr_wdata_i)) else $error("p1 write");
   a_write_port2: assert property (
      clk_en_i && sfr_wr_i && sfr_addr_i == 8'h92 |=>
      port2_function_select_o == $past(sfr_wdata_i)) else $error("p2 write");
   a_write_port3: assert property (
      clk_en_i && sfr_wr_i && sfr_addr_i == 8'h93 |=>
      port3_function_select_o == ($past(sfr_wdata_i) & 8'hFC))
      else $error("p3 write");
   a_hit_mapped: assert property (
      req && mapped |=> sfr_hit_o) else $error("hit missing");
   a_miss_quiet: assert property (
      req && !mapped |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
      else $error("unmapped answered");
   a_read_back: assert property (
      clk_en_i && sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'h91 |=>
      sfr_rdata_o == $past(port1_function_select_o)) else $error("read p1");
   a_i2c_open_drain: assert property (
      live && $past(port1_function_select_o[0]) |-> !port1_pad_o.out[0] &&
      port1_pad_o.oe[0] == !$past(periph_i.i2c_a_clock_line))
      else $error("i2c pad");
   a_analog_hiz: assert property (
      live |-> (port1_pad_o.oe[5:2] & $past(port1_function_select_o[5:2]))
      == 4'h0) else $error("analog pad driven");
   a_hsync_drive: assert property (
      live && $past(port3_function_select_o[2]) |-> port3_pad_o.oe[2] &&
      port3_pad_o.out[2] == $past(periph_i.horizontal_sync_output))
      else $error("sync pad");
endmodule
bind port_alt_function_select port_alt_function_select_asserts chk (
   .ref_clk_i, .rst_n_i, .clk_en_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
   .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o, .periph_i, .port1_pad_o,
   .port3_pad_o, .port1_function_select_o, .port2_function_select_o,
   .port3_function_select_o);

// File: tb/peripheral_model.sv
/* Stand-in for the on-chip peripherals and board pins. Assumes the bench
   steers every level through one control byte. */
`timescale 1ns/100ps
module peripheral_model (
   input  wire logic [7:0]                                level_i,
   output      port_alt_function_select_pkg::periph_out_t periph_o,
   output      logic [7:0]                                pin_o
);
   // Each peripheral line follows a fixed bit, clamp_pulse its inverse, so expectations stay simple
   always_comb
   begin
      periph_o.i2c_a_clock_line = level_i[0];
      periph_o.i2c_a_data_line = level_i[1];
      periph_o.i2c_b_clock_line = level_i[6];
      periph_o.i2c_b_data_line = level_i[7];
      periph_o.static_pulse_out = level_i[7:2];
      periph_o.dynamic_pulse_out = level_i[1:0];
      periph_o.pulse_out_6 = level_i[4];
      periph_o.pulse_out_7 = level_i[5];
      periph_o.clamp_pulse = ~level_i[5];
      periph_o.clamp_not_pulse = level_i[3];
      periph_o.pattern_generator_output = level_i[6];
      periph_o.vertical_sync_output = level_i[3];
      periph_o.horizontal_sync_output = level_i[2];
   end
   // Board pin levels seen by the pad inputs
   assign pin_o = level_i;
endmodule

// File: tb/port_alt_function_select_test.sv
/* Bench of the pin function selector: SFR access tasks and mux checks.
   Assumes the peripheral model drives the peripheral side. */
`timescale 1ns/100ps
module port_alt_function_select_test;
   logic                                      ref_clk_i, rst_n_i, clk_en_i;
   logic [7:0]                                sfr_addr_i, sfr_wdata_i;
   logic                                      sfr_wr_i, sfr_rd_i, sfr_hit_o;
   logic [7:0]                                sfr_rdata_o, pulse_push_pull_i;
   logic [7:0]                                port1_pin_i, port3_pin_i, rv;
   port_alt_function_select_pkg::pin_drive_t  port1_gen_i, port2_gen_i;
   port_alt_function_select_pkg::pin_drive_t  port3_gen_i, port1_pad_o;
   port_alt_function_select_pkg::pin_drive_t  port2_pad_o, port3_pad_o;
   port_alt_function_select_pkg::periph_out_t periph_i;
   logic                                      i2c_a_data_in_o, hv;
   logic                                      i2c_a_clock_in_o;
   logic                                      i2c_b_data_in_o;
   logic                                      i2c_b_clock_in_o;
   logic                                      green_sync_input_o;
   logic [3:0]                                analog_in_sel_o;
   logic [7:0]                                port1_function_select_o;
   logic [7:0]                                port2_function_select_o;
   logic [7:0]                                port3_function_select_o;
   logic [7:0]                                lv;
   logic [7:0]                                level;
   int                                        mismatches, check_count;
   port_alt_function_select dut (.*);
   peripheral_model partner (.level_i(level), .periph_o(periph_i),
      .pin_o(port1_pin_i));
   assign port3_pin_i = port1_pin_i;
   initial
   begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] act, input logic [15:0] exp);
      check_count++;
      if (act !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t act %h exp %h", $time, act, exp);
      end
   endtask
   // One strobe cycle; the answer is sampled mid-cycle once it has landed
   task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_wr_i <= w;
      sfr_rd_i <= !w;
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      @(posedge ref_clk_i);
      sfr_wr_i <= 1'b0;
      sfr_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      rv = sfr_rdata_o;
      hv = sfr_hit_o;
   endtask
   // Fixed settle: pads lag one edge, pin synchronisers a few more
   task automatic settle();
      repeat (8) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   initial
   begin
      #100000;
      mismatches++;
      end_of_test();
   end
   initial
   begin
      {rst_n_i, sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = '0;
      clk_en_i = 1'b1;
      pulse_push_pull_i = 8'hFF;
      level = 8'h00;
      port1_gen_i = {8'hAA, 8'hFF};
      port2_gen_i = {8'hAA, 8'hFF};
      port3_gen_i = {8'hAA, 8'hFF};
      mismatches = 0;
      check_count = 0;
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         sfr(1'b0, 8'h91 + 8'(i), 8'h00);
         chk({7'h00, hv, rv}, 16'h0100);
         sfr(1'b1, 8'h91 + 8'(i), 8'hFF);
         sfr(1'b0, 8'h91 + 8'(i), 8'h00);
         chk({7'h00, hv, rv}, (i == 2) ? 16'h01FC : 16'h01FF);
      end
      sfr(1'b1, 8'h94, 8'h00);
      sfr(1'b0, 8'h90, 8'h00);
      chk({7'h00, hv, rv}, 16'h0000);
      chk({port1_function_select_o, port2_function_select_o}, 16'hFFFF);
      $display("registers done");
      for (int j = 0; j < 2; j++)
      begin
         lv = (j == 0) ? 8'h24 : 8'hDB;
         @(posedge ref_clk_i);
         level <= lv;
         pulse_push_pull_i <= 8'hFF;
         settle();
         chk({port1_pad_o.oe, port1_pad_o.out & 8'hC3}, {~lv[7:6], 4'h0,
            ~lv[1:0], 8'h00});
         chk({port2_pad_o.oe, port2_pad_o.out}, {8'hFF, lv});
         chk({port3_pad_o.oe, port3_pad_o.out & 8'h7F}, {8'h7F, 1'b0, lv[6],
            lv[3] ^ lv[5], lv[4], lv[3:2], 2'b10});
         chk({7'h00, i2c_a_data_in_o, i2c_a_clock_in_o, i2c_b_data_in_o,
            i2c_b_clock_in_o, green_sync_input_o, analog_in_sel_o},
            {7'h00, lv[1:0], lv[7:6], lv[7], 4'hF});
         @(posedge ref_clk_i);
         pulse_push_pull_i <= 8'h00;
         settle();
         chk({port2_pad_o.oe, port2_pad_o.out}, {~lv, 8'h00});
      end
      $display("mux done");
      sfr(1'b1, 8'h91, 8'h0C);
      sfr(1'b1, 8'h93, 8'h00);
      settle();
      chk({port1_pad_o.oe, port1_pad_o.out & 8'hF3}, 16'hF3A2);
      chk({1'b0, i2c_a_data_in_o, i2c_b_clock_in_o, green_sync_input_o,
         analog_in_sel_o, port3_pad_o.out}, 16'h63AA);
      // A frozen cycle must swallow the write
      @(posedge ref_clk_i);
      clk_en_i <= 1'b0;
      sfr(1'b1, 8'h91, 8'h00);
      @(posedge ref_clk_i);
      clk_en_i <= 1'b1;
      @(negedge ref_clk_i);
      chk({8'h00, port1_function_select_o}, 16'h000C);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      settle();
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      settle();
      chk({port2_function_select_o, port1_pad_o.out}, 16'h00AA);
      $display("reset done");
      end_of_test();
   end
endmodule
